// ### shared/pss_pkg.sv
package pss_pkg;

	// ************************************************************
	// Register byte offsets
	// ************************************************************
	localparam logic [7:0] PSS_ADDR_PERIPH_DIS = 8'h00;
	localparam logic [7:0] PSS_ADDR_OSC_CTRL = 8'h04;
	localparam logic [7:0] PSS_ADDR_RESET_CAUSE = 8'h08;
	localparam logic [7:0] PSS_ADDR_POWER_STATE = 8'h0C;

	// ************************************************************
	// peripheral_disable_1 layout
	// ************************************************************
	localparam logic [15:0] PSS_PD1_RESET = 16'h0000;
	localparam logic [15:0] PSS_PD1_IMPL_MASK = 16'hFEFB;
	localparam int PSS_TIMER_FIVE_OFF = 15;
	localparam int PSS_TIMER_FOUR_OFF = 14;
	localparam int PSS_TIMER_THREE_OFF = 13;
	localparam int PSS_TIMER_TWO_OFF = 12;
	localparam int PSS_TIMER_ONE_OFF = 11;
	localparam int PSS_QUADRATURE_DECODER_OFF = 10;
	localparam int PSS_PULSE_WIDTH_UNIT_OFF = 9;
	localparam int PSS_TWO_WIRE_UNIT_OFF = 7;
	localparam int PSS_SERIAL_PORT_TWO_OFF = 6;
	localparam int PSS_SERIAL_PORT_ONE_OFF = 5;
	localparam int PSS_SYNC_SERIAL_TWO_OFF = 4;
	localparam int PSS_SYNC_SERIAL_ONE_OFF = 3;
	localparam int PSS_CAN_UNIT_OFF = 1;
	localparam int PSS_CONVERTER_UNIT_OFF = 0;

	// ************************************************************
	// oscillator_control_register layout
	// ************************************************************
	localparam int PSS_CUR_OSC_LSB = 12;
	localparam int PSS_NEW_OSC_LSB = 8;
	localparam int PSS_CLOCK_LOCK_BIT = 7;
	localparam logic [2:0] PSS_OSC_RESET = 3'h0;

	// ************************************************************
	// reset_cause_register layout
	// ************************************************************
	localparam int PSS_WATCHDOG_TIMEOUT_FLAG = 4;
	localparam int PSS_SLEEP_FLAG = 3;
	localparam int PSS_IDLE_FLAG = 2;
	localparam logic [15:0] PSS_RESET_CAUSE_MASK = 16'h001C;
	localparam logic [15:0] PSS_RESET_CAUSE_RESET = 16'h0000;

	// ************************************************************
	// Instruction operand, bus answers, states
	// ************************************************************
	localparam logic PSS_OP_SLEEP = 1'h0;
	localparam logic PSS_OP_IDLE = 1'h1;
	localparam logic [1:0] PSS_RESP_OKAY = 2'h0;
	localparam logic [1:0] PSS_RESP_DECERR = 2'h3;

	typedef enum logic [2:0] {
		PSS_RUN = 3'h1,
		PSS_IDLE = 3'h2,
		PSS_SLEEP = 3'h4
	} pss_state_type;

endpackage

// ### src/pss_sync2.sv
module pss_sync2 #(
	parameter int WIDTH = 1
) (
	// Clock and reset
	input wire logic core_clk,
	input wire logic resetn,
	// Data
	input wire logic [WIDTH-1:0] asyncIn,
	output logic [WIDTH-1:0] syncOut
);

	logic [WIDTH-1:0] stageOne_reg;

	// First stage feeds only the second
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			stageOne_reg <= '0;
			syncOut <= '0;
		end else begin
			stageOne_reg <= asyncIn;
			syncOut <= stageOne_reg;
		end
	end

endmodule

// ### src/pss_power_save.sv
// Overview of operation
// - Sleep stops the system clock and halts execution until a wake-up event.
// - Idle halts the CPU while peripherals stay clocked and running.
// - Both states are entered only through the power-save instruction, whose operand picks one.
// - Any enabled interrupt, watchdog timeout or reset brings the device back to run.
// - Entering sleep shuts the system clock source and its on-chip oscillator off.
// - The clock-failure monitor is inactive while sleeping.
// - The low-power RC clock keeps running in sleep whenever the watchdog is enabled.
// - An enabled watchdog is cleared just before sleep is entered.
// - System-clocked peripherals stop in sleep; externally clocked ones and pin change may wake.
// - After sleep the processor resumes on the clock source active at entry.
// - The new-oscillator field is writable only while clock configuration is unlocked.
// - A disable bit of 1 turns its peripheral off, 0 on; all reset to 0.
// - Bits 15-11 timers five-one, 10 quadrature, 9 PWM, 7 two-wire, 6-3 serial, 1 CAN, 0 ADC.
// - The power-save instruction clears the watchdog-timeout flag, bit 4 of the reset cause.
module pss_power_save #(
	parameter int ADDR_W = 8,
	parameter logic [15:0] EXT_CLOCKED_MASK = 16'h0000
) (
	// Clock and reset
	input wire logic core_clk,
	input wire logic resetn,
	// AXI4-Lite write address and data
	input wire logic [ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	// AXI4-Lite write response
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// AXI4-Lite read
	input wire logic [ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// CPU core
	input wire logic powerSaveExec,
	input wire logic powerSaveOperand,
	input wire logic enabledIrqPending,
	input wire logic warmResetReq,
	output logic cpuHalt,
	// Oscillator and watchdog
	input wire logic configLocked,
	input wire logic watchdogEnable,
	input wire logic watchdogTimeoutAsync,
	output logic sysClockEnable,
	output logic oscillatorEnable,
	output logic failSafeMonitorEnable,
	output logic lowPowerRcEnable,
	output logic watchdogClear,
	output logic [2:0] activeClockSource,
	// Pins and peripherals
	input wire logic pinChangeAsync,
	input wire logic extClockWakeAsync,
	output logic [15:0] periphClockEnable,
	output logic [15:0] periphAccessEnable
);

	// ************************************************************
	// Synchronised external events
	// ************************************************************
	logic [2:0] syncEvents;
	logic watchdogTimeout, pinChange, extClockWake;
	pss_sync2 #(
		.WIDTH(3)
	) eventSync (
		.core_clk(core_clk),
		.resetn(resetn),
		.asyncIn({watchdogTimeoutAsync, pinChangeAsync, extClockWakeAsync}),
		.syncOut(syncEvents)
	);
	assign {watchdogTimeout, pinChange, extClockWake} = syncEvents;

	// ************************************************************
	// Bus slave
	// ************************************************************
	logic awReady_reg, awReady_next;
	logic wReady_reg, wReady_next;
	logic bValid_reg, bValid_next;
	logic [1:0] bResp_reg, bResp_next;
	logic [7:0] awAddr_reg, awAddr_next;
	logic [31:0] wData_reg, wData_next;
	logic [3:0] wStrb_reg, wStrb_next;
	logic arReady_reg, arReady_next;
	logic rValid_reg, rValid_next;
	logic [31:0] rData_reg, rData_next;
	logic [1:0] rResp_reg, rResp_next;
	logic writeCommit;
	logic [7:0] rdAddr;

	pss_pkg::pss_state_type state_reg, state_next;
	logic [15:0] periphDisable_reg, periphDisable_next;
	logic [2:0] newOsc_reg, newOsc_next;
	logic [2:0] curOsc_reg, curOsc_next;
	logic [15:0] resetCause_reg, resetCause_next;
	function automatic logic [15:0] mergeLanes(input logic [15:0] old, input logic [31:0] data,
			input logic [3:0] strb);
		return {strb[1] ? data[15:8] : old[15:8], strb[0] ? data[7:0] : old[7:0]};
	endfunction
	function automatic logic known(input logic [7:0] a);
		return a == pss_pkg::PSS_ADDR_PERIPH_DIS || a == pss_pkg::PSS_ADDR_OSC_CTRL ||
			a == pss_pkg::PSS_ADDR_RESET_CAUSE || a == pss_pkg::PSS_ADDR_POWER_STATE;
	endfunction

	// Address and data slots are held until the response is taken
	assign writeCommit = !awReady_reg && !wReady_reg && !bValid_reg;
	assign rdAddr = {s_axi_araddr[7:2], 2'b00};

	always_comb begin
		awReady_next = awReady_reg;
		wReady_next = wReady_reg;
		bValid_next = bValid_reg;
		bResp_next = bResp_reg;
		awAddr_next = awAddr_reg;
		wData_next = wData_reg;
		wStrb_next = wStrb_reg;
		arReady_next = arReady_reg;
		rValid_next = rValid_reg;
		rData_next = rData_reg;
		rResp_next = rResp_reg;
		if (s_axi_awvalid && awReady_reg) begin
			awReady_next = 1'b0;
			awAddr_next = {s_axi_awaddr[7:2], 2'b00};
		end
		if (s_axi_wvalid && wReady_reg) begin
			wReady_next = 1'b0;
			wData_next = s_axi_wdata;
			wStrb_next = s_axi_wstrb;
		end
		if (writeCommit) begin
			bValid_next = 1'b1;
			bResp_next = known(awAddr_reg) ? pss_pkg::PSS_RESP_OKAY : pss_pkg::PSS_RESP_DECERR;
		end
		if (bValid_reg && s_axi_bready) begin
			bValid_next = 1'b0;
			awReady_next = 1'b1;
			wReady_next = 1'b1;
		end
		if (s_axi_arvalid && arReady_reg) begin
			arReady_next = 1'b0;
			rValid_next = 1'b1;
			rResp_next = pss_pkg::PSS_RESP_OKAY;
			case (rdAddr)
				pss_pkg::PSS_ADDR_PERIPH_DIS: rData_next = {16'h0000, periphDisable_reg};
				pss_pkg::PSS_ADDR_OSC_CTRL: rData_next = {16'h0000, 1'b0, curOsc_reg, 1'b0,
					newOsc_reg, configLocked, 7'h00};
				pss_pkg::PSS_ADDR_RESET_CAUSE: rData_next = {16'h0000, resetCause_reg};
				pss_pkg::PSS_ADDR_POWER_STATE: rData_next = {29'h0000_0000, state_reg};
				default: begin
					rData_next = 32'h0000_0000;
					rResp_next = pss_pkg::PSS_RESP_DECERR;
				end
			endcase
		end
		if (rValid_reg && s_axi_rready) begin
			rValid_next = 1'b0;
			arReady_next = 1'b1;
		end
	end

	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			awReady_reg <= 1'b1;
			wReady_reg <= 1'b1;
			bValid_reg <= 1'b0;
			bResp_reg <= pss_pkg::PSS_RESP_OKAY;
			awAddr_reg <= 8'h00;
			wData_reg <= 32'h0000_0000;
			wStrb_reg <= 4'h0;
			arReady_reg <= 1'b1;
			rValid_reg <= 1'b0;
			rData_reg <= 32'h0000_0000;
			rResp_reg <= pss_pkg::PSS_RESP_OKAY;
		end else begin
			awReady_reg <= awReady_next;
			wReady_reg <= wReady_next;
			bValid_reg <= bValid_next;
			bResp_reg <= bResp_next;
			awAddr_reg <= awAddr_next;
			wData_reg <= wData_next;
			wStrb_reg <= wStrb_next;
			arReady_reg <= arReady_next;
			rValid_reg <= rValid_next;
			rData_reg <= rData_next;
			rResp_reg <= rResp_next;
		end
	end

	assign s_axi_awready = awReady_reg;
	assign s_axi_wready = wReady_reg;
	assign s_axi_bvalid = bValid_reg;
	assign s_axi_bresp = bResp_reg;
	assign s_axi_arready = arReady_reg;
	assign s_axi_rvalid = rValid_reg;
	assign s_axi_rdata = rData_reg;
	assign s_axi_rresp = rResp_reg;

	// ************************************************************
	// Power state and control registers
	// ************************************************************
	logic wakeNow;
	logic enterSleep;
	logic [15:0] periphClockNext;
	logic cpuHalt_next, sysClock_next, lowPowerRc_next, watchdogClear_next;

	assign wakeNow = enabledIrqPending || watchdogTimeout || warmResetReq || pinChange ||
		extClockWake;
	assign enterSleep = state_reg == pss_pkg::PSS_RUN && powerSaveExec &&
		powerSaveOperand == pss_pkg::PSS_OP_SLEEP;

	always_comb begin
		state_next = state_reg;
		periphDisable_next = periphDisable_reg;
		newOsc_next = newOsc_reg;
		curOsc_next = curOsc_reg;
		resetCause_next = resetCause_reg;
		case (state_reg)
			pss_pkg::PSS_RUN: begin
				if (powerSaveExec) begin
					state_next = powerSaveOperand == pss_pkg::PSS_OP_SLEEP ?
						pss_pkg::PSS_SLEEP : pss_pkg::PSS_IDLE;
				end
			end
			pss_pkg::PSS_IDLE, pss_pkg::PSS_SLEEP: begin
				if (wakeNow) begin
					state_next = pss_pkg::PSS_RUN;
				end
			end
			default: state_next = pss_pkg::PSS_RUN;
		endcase
		if (writeCommit && awAddr_reg == pss_pkg::PSS_ADDR_PERIPH_DIS) begin
			periphDisable_next = mergeLanes(periphDisable_reg, wData_reg, wStrb_reg) &
				pss_pkg::PSS_PD1_IMPL_MASK;
		end
		if (writeCommit && awAddr_reg == pss_pkg::PSS_ADDR_OSC_CTRL && !configLocked &&
				wStrb_reg[1]) begin
			newOsc_next = wData_reg[pss_pkg::PSS_NEW_OSC_LSB +: 3];
		end
		if (state_reg == pss_pkg::PSS_RUN && state_next == pss_pkg::PSS_RUN) begin
			curOsc_next = newOsc_reg;
		end
		if (writeCommit && awAddr_reg == pss_pkg::PSS_ADDR_RESET_CAUSE) begin
			resetCause_next = mergeLanes(resetCause_reg, wData_reg, wStrb_reg) &
				pss_pkg::PSS_RESET_CAUSE_MASK;
		end
		if (state_reg == pss_pkg::PSS_RUN && powerSaveExec) begin
			resetCause_next[pss_pkg::PSS_WATCHDOG_TIMEOUT_FLAG] = 1'b0;
			if (powerSaveOperand == pss_pkg::PSS_OP_SLEEP) begin
				resetCause_next[pss_pkg::PSS_SLEEP_FLAG] = 1'b1;
			end else begin
				resetCause_next[pss_pkg::PSS_IDLE_FLAG] = 1'b1;
			end
		end
		// Hardware set beats any clear in the same cycle
		if (watchdogTimeout) begin
			resetCause_next[pss_pkg::PSS_WATCHDOG_TIMEOUT_FLAG] = 1'b1;
		end
		cpuHalt_next = state_next != pss_pkg::PSS_RUN;
		// system clock and oscillator off in sleep
		sysClock_next = state_next != pss_pkg::PSS_SLEEP;
		lowPowerRc_next = sysClock_next || watchdogEnable;
		watchdogClear_next = enterSleep && watchdogEnable;
	end

	generate
		for (genvar i = 0; i < 16; i++) begin : gateBits
			assign periphClockNext[i] = pss_pkg::PSS_PD1_IMPL_MASK[i] && !periphDisable_next[i] &&
				(sysClock_next || EXT_CLOCKED_MASK[i]);
		end
	endgenerate

	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			state_reg <= pss_pkg::PSS_RUN;
			periphDisable_reg <= pss_pkg::PSS_PD1_RESET;
			newOsc_reg <= pss_pkg::PSS_OSC_RESET;
			curOsc_reg <= pss_pkg::PSS_OSC_RESET;
			resetCause_reg <= pss_pkg::PSS_RESET_CAUSE_RESET;
			cpuHalt <= 1'b0;
			sysClockEnable <= 1'b1;
			oscillatorEnable <= 1'b1;
			failSafeMonitorEnable <= 1'b1;
			lowPowerRcEnable <= 1'b1;
			watchdogClear <= 1'b0;
			activeClockSource <= pss_pkg::PSS_OSC_RESET;
			periphClockEnable <= pss_pkg::PSS_PD1_IMPL_MASK;
			periphAccessEnable <= pss_pkg::PSS_PD1_IMPL_MASK;
		end else begin
			state_reg <= state_next;
			periphDisable_reg <= periphDisable_next;
			newOsc_reg <= newOsc_next;
			curOsc_reg <= curOsc_next;
			resetCause_reg <= resetCause_next;
			cpuHalt <= cpuHalt_next;
			sysClockEnable <= sysClock_next;
			oscillatorEnable <= sysClock_next;
			// monitor idle while the clock is stopped
			failSafeMonitorEnable <= sysClock_next;
			lowPowerRcEnable <= lowPowerRc_next;
			watchdogClear <= watchdogClear_next;
			activeClockSource <= curOsc_next;
			periphClockEnable <= periphClockNext;
			periphAccessEnable <= ~periphDisable_next & pss_pkg::PSS_PD1_IMPL_MASK;
		end
	end

	// ************************************************************
	// Checks
	// ************************************************************
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!resetn);
	sequence sleepEntry;
		state_reg == pss_pkg::PSS_RUN && powerSaveExec && powerSaveOperand == pss_pkg::PSS_OP_SLEEP;
	endsequence
	sequence idleEntry;
		state_reg == pss_pkg::PSS_RUN && powerSaveExec && powerSaveOperand == pss_pkg::PSS_OP_IDLE;
	endsequence
	sleep_stops_a: assert property (sleepEntry |=> state_reg == pss_pkg::PSS_SLEEP && cpuHalt &&
		!sysClockEnable && !oscillatorEnable) else $error("sleep entry did not stop clocks");
	idle_keeps_a: assert property (idleEntry |=> state_reg == pss_pkg::PSS_IDLE && cpuHalt &&
		sysClockEnable && periphClockEnable == periphAccessEnable)
		else $error("idle entry wrong");
	wake_resume_a: assert property (state_reg != pss_pkg::PSS_RUN && wakeNow |=>
		state_reg == pss_pkg::PSS_RUN && !cpuHalt) else $error("no wake-up");
	monitor_off_a: assert property (state_reg == pss_pkg::PSS_SLEEP |->
		!failSafeMonitorEnable) else $error("clock monitor active in sleep");
	rc_kept_a: assert property (state_reg == pss_pkg::PSS_SLEEP && watchdogEnable |=>
		lowPowerRcEnable) else $error("RC clock stopped with watchdog on");
	watchdog_clear_a: assert property (sleepEntry and watchdogEnable |=> watchdogClear ##1
		!watchdogClear) else $error("watchdog clear pulse wrong");
	periph_sleep_a: assert property (state_reg == pss_pkg::PSS_SLEEP |->
		(periphClockEnable & ~EXT_CLOCKED_MASK) == 16'h0000) else $error("peripheral clocked");
	source_kept_a: assert property (state_reg != pss_pkg::PSS_RUN ##1
		state_reg == pss_pkg::PSS_RUN |-> $stable(activeClockSource))
		else $error("clock source changed across sleep");
	lock_hold_a: assert property (writeCommit && configLocked |=> $stable(newOsc_reg))
		else $error("locked oscillator field changed");
	access_gate_a: assert property (1'b1 |-> periphAccessEnable ==
		(~periphDisable_reg & pss_pkg::PSS_PD1_IMPL_MASK)) else $error("access gate mismatch");
	unimp_zero_a: assert property ((periphDisable_reg & ~pss_pkg::PSS_PD1_IMPL_MASK) ==
		16'h0000) else $error("unimplemented disable bit set");
	flag_clear_a: assert property (state_reg == pss_pkg::PSS_RUN && powerSaveExec &&
		!watchdogTimeout |=> !resetCause_reg[pss_pkg::PSS_WATCHDOG_TIMEOUT_FLAG])
		else $error("timeout flag not cleared");

endmodule

// ### testbench/pss_cpu_model.sv
module pss_cpu_model (
	// Clock and reset
	input wire logic core_clk,
	input wire logic resetn,
	// Bench request
	input wire logic instrReq,
	input wire logic instrOp,
	// Design side
	input wire logic cpuHalt,
	output logic powerSaveExec,
	output logic powerSaveOperand
);
	timeunit 1ns;
	timeprecision 1ns;

	// ************************************************************
	// Instruction issue
	// ************************************************************
	// Power-save only as a one-cycle instruction from a running core
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			powerSaveExec <= 1'h0;
			powerSaveOperand <= 1'h0;
		end else begin
			// A halted core fetches nothing, so no instruction while halted
			powerSaveExec <= instrReq && !cpuHalt && !powerSaveExec;
			if (instrReq) begin
				powerSaveOperand <= instrOp;
			end
		end
	end
endmodule

// ### testbench/tb_power_save_module_gating.sv
module tb_power_save_module_gating;
	timeunit 1ns;
	timeprecision 1ns;

	// ************************************************************
	// Signals
	// ************************************************************
	logic core_clk = 1'h0;
	logic resetn = 1'h0;
	logic [7:0] awAddr = 8'h00, arAddr = 8'h00;
	logic [31:0] wData = 32'h0000_0000, rd;
	logic [3:0] wStrb = 4'hF;
	logic awValid = 1'h0, wValid = 1'h0, arValid = 1'h0;
	logic [4:0] wakeVec = 5'h00;
	logic configLocked = 1'h0, watchdogEnable = 1'h0, instrReq = 1'h0, instrOp = 1'h0;
	logic awReady, wReady, bValid, arReady, rValid, powerSaveExec, powerSaveOperand, cpuHalt;
	logic [1:0] bResp, rResp, rr;
	logic [31:0] rData;
	logic sysClockEnable, oscillatorEnable, failSafeMonitorEnable, lowPowerRcEnable;
	logic watchdogClear;
	logic [2:0] activeClockSource;
	logic [15:0] periphClockEnable, periphAccessEnable;
	int nErrors = 0, compares = 0, cycles = 0, i;
	int offBits[14] = '{15, 14, 13, 12, 11, 10, 9, 7, 6, 5, 4, 3, 1, 0};

	always #50 core_clk = ~core_clk;

	// Timer one runs from its own pin clock, so it keeps its clock in sleep
	pss_power_save #(.EXT_CLOCKED_MASK(16'h0800)) pss_power_save_inst (.core_clk(core_clk),
		.resetn(resetn),
		.s_axi_awaddr(awAddr), .s_axi_awvalid(awValid), .s_axi_awready(awReady),
		.s_axi_wdata(wData), .s_axi_wstrb(wStrb), .s_axi_wvalid(wValid), .s_axi_wready(wReady),
		.s_axi_bresp(bResp), .s_axi_bvalid(bValid), .s_axi_bready(1'h1),
		.s_axi_araddr(arAddr), .s_axi_arvalid(arValid), .s_axi_arready(arReady),
		.s_axi_rdata(rData), .s_axi_rresp(rResp), .s_axi_rvalid(rValid), .s_axi_rready(1'h1),
		.powerSaveExec(powerSaveExec), .powerSaveOperand(powerSaveOperand),
		.enabledIrqPending(wakeVec[0]), .warmResetReq(wakeVec[1]), .cpuHalt(cpuHalt),
		.configLocked(configLocked), .watchdogEnable(watchdogEnable),
		.watchdogTimeoutAsync(wakeVec[2]), .sysClockEnable(sysClockEnable),
		.oscillatorEnable(oscillatorEnable), .failSafeMonitorEnable(failSafeMonitorEnable),
		.lowPowerRcEnable(lowPowerRcEnable), .watchdogClear(watchdogClear),
		.activeClockSource(activeClockSource), .pinChangeAsync(wakeVec[3]),
		.extClockWakeAsync(wakeVec[4]), .periphClockEnable(periphClockEnable),
		.periphAccessEnable(periphAccessEnable));

	pss_cpu_model pss_cpu_model_inst (.core_clk(core_clk), .resetn(resetn),
		.instrReq(instrReq), .instrOp(instrOp), .cpuHalt(cpuHalt),
		.powerSaveExec(powerSaveExec), .powerSaveOperand(powerSaveOperand));

	// ************************************************************
	// Tasks
	// ************************************************************
	task automatic conclude;
		if (nErrors == 0 && compares > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			nErrors++;
			$display("mismatch %s expected %h seen %h", name, exp, seen);
		end
	endtask

	// Waits only on the answer; the cycle ceiling ends a hang
	task automatic axiWrite(input logic [7:0] a, input logic [31:0] d,
			input logic [1:0] eb = pss_pkg::PSS_RESP_OKAY, input logic [3:0] s = 4'hF);
		@(posedge core_clk);
		awAddr <= a;
		wData <= d;
		wStrb <= s;
		awValid <= 1'h1;
		wValid <= 1'h1;
		forever begin
			@(posedge core_clk);
			if (awReady === 1'h1) awValid <= 1'h0;
			if (wReady === 1'h1) wValid <= 1'h0;
			if (bValid === 1'h1) break;
		end
		check("bresp", 32'(bResp), 32'(eb));
	endtask

	task automatic axiRead(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
		@(posedge core_clk);
		arAddr <= a;
		arValid <= 1'h1;
		forever begin
			@(posedge core_clk);
			if (arReady === 1'h1) arValid <= 1'h0;
			if (rValid === 1'h1) begin
				rd = rData;
				rr = rResp;
				break;
			end
		end
		check("rdata", rd, exp);
		check("rresp", 32'(rr), 32'(er));
	endtask

	task automatic settle;
		@(posedge core_clk);
		#1;
	endtask

	task automatic enter(input logic op);
		@(posedge core_clk);
		instrReq <= 1'h1;
		instrOp <= op;
		@(posedge core_clk);
		instrReq <= 1'h0;
		for (int n = 0; n < 10 && cpuHalt !== 1'h1; n++) settle();
		check("cpuHalt", 32'(cpuHalt), 32'h1);
	endtask

	task automatic wake(input int b);
		@(posedge core_clk);
		wakeVec[b] <= 1'h1;
		for (int n = 0; n < 10 && cpuHalt !== 1'h0; n++) settle();
		check("cpuHalt", 32'(cpuHalt), 32'h0);
		@(posedge core_clk);
		wakeVec[b] <= 1'h0;
		// Let the wake synchronisers drain before the next entry
		repeat (4) @(posedge core_clk);
	endtask

	always @(posedge core_clk) begin
		cycles <= cycles + 1;
		if (cycles == 5000) begin
			nErrors++;
			conclude();
		end
	end

	// ************************************************************
	// Sequence
	// ************************************************************
	initial begin
		repeat (3) @(posedge core_clk);
		resetn <= 1'h1;
		axiRead(pss_pkg::PSS_ADDR_PERIPH_DIS, 32'h0000_0000, pss_pkg::PSS_RESP_OKAY);
		check("clkEn", 32'(periphClockEnable), 32'h0000_FEFB);
		axiWrite(pss_pkg::PSS_ADDR_PERIPH_DIS, 32'h0000_FFFF);
		axiRead(pss_pkg::PSS_ADDR_PERIPH_DIS, 32'h0000_FEFB, pss_pkg::PSS_RESP_OKAY);
		settle();
		check("clkEn", 32'(periphClockEnable), 32'h0000_0000);
		check("accEn", 32'(periphAccessEnable), 32'h0000_0000);
		for (i = 0; i < 14; i++) begin
			axiWrite(pss_pkg::PSS_ADDR_PERIPH_DIS, 32'h1 << offBits[i]);
			settle();
			check("clkEn", 32'(periphClockEnable), 32'hFEFB & ~(32'h1 << offBits[i]));
		end
		// Re-enables the converter unit, the last one the loop above disabled
		axiWrite(pss_pkg::PSS_ADDR_PERIPH_DIS, 32'h0000_0000);
		// Low lane only: upper disable bits stay clear
		axiWrite(pss_pkg::PSS_ADDR_PERIPH_DIS, 32'h0000_FFFF, pss_pkg::PSS_RESP_OKAY, 4'h1);
		axiRead(pss_pkg::PSS_ADDR_PERIPH_DIS, 32'h0000_00FB, pss_pkg::PSS_RESP_OKAY);
		axiWrite(8'h10, 32'h0000_FFFF, pss_pkg::PSS_RESP_DECERR);
		axiRead(pss_pkg::PSS_ADDR_PERIPH_DIS, 32'h0000_00FB, pss_pkg::PSS_RESP_OKAY);
		axiWrite(pss_pkg::PSS_ADDR_PERIPH_DIS, 32'h0000_0000);
		axiRead(8'h10, 32'h0000_0000, pss_pkg::PSS_RESP_DECERR);
		axiWrite(pss_pkg::PSS_ADDR_OSC_CTRL, 32'h0000_0500);
		axiRead(pss_pkg::PSS_ADDR_OSC_CTRL, 32'h0000_5500, pss_pkg::PSS_RESP_OKAY);
		@(posedge core_clk);
		configLocked <= 1'h1;
		axiWrite(pss_pkg::PSS_ADDR_OSC_CTRL, 32'h0000_0200);
		axiRead(pss_pkg::PSS_ADDR_OSC_CTRL, 32'h0000_5580, pss_pkg::PSS_RESP_OKAY);
		axiWrite(pss_pkg::PSS_ADDR_RESET_CAUSE, 32'h0000_0010);
		@(posedge core_clk);
		configLocked <= 1'h0;
		watchdogEnable <= 1'h1;
		enter(pss_pkg::PSS_OP_SLEEP);
		check("sysClk", 32'(sysClockEnable), 32'h0);
		check("osc", 32'(oscillatorEnable), 32'h0);
		check("monitor", 32'(failSafeMonitorEnable), 32'h0);
		check("rc", 32'(lowPowerRcEnable), 32'h1);
		check("wdClr", 32'(watchdogClear), 32'h1);
		check("clkEn", 32'(periphClockEnable), 32'h0000_0800);
		axiRead(pss_pkg::PSS_ADDR_POWER_STATE, 32'h4, pss_pkg::PSS_RESP_OKAY);
		axiRead(pss_pkg::PSS_ADDR_RESET_CAUSE, 32'h8, pss_pkg::PSS_RESP_OKAY);
		wake(0);
		check("source", 32'(activeClockSource), 32'h5);
		enter(pss_pkg::PSS_OP_IDLE);
		check("sysClk", 32'(sysClockEnable), 32'h1);
		check("clkEn", 32'(periphClockEnable), 32'h0000_FEFB);
		axiRead(pss_pkg::PSS_ADDR_POWER_STATE, 32'h2, pss_pkg::PSS_RESP_OKAY);
		wake(2);
		axiRead(pss_pkg::PSS_ADDR_RESET_CAUSE, 32'h1C, pss_pkg::PSS_RESP_OKAY);
		@(posedge core_clk);
		watchdogEnable <= 1'h0;
		enter(pss_pkg::PSS_OP_SLEEP);
		check("rc", 32'(lowPowerRcEnable), 32'h0);
		check("wdClr", 32'(watchdogClear), 32'h0);
		wake(3);
		enter(pss_pkg::PSS_OP_IDLE);
		wake(4);
		enter(pss_pkg::PSS_OP_SLEEP);
		wake(1);
		conclude();
	end
endmodule
